// [snc_cfg.svh]
`ifndef SNC_CFG_SVH
`define SNC_CFG_SVH
// Opcodes
`define SNC_OP_SAVE 8'h3C
`define SNC_OP_RESTORE 8'h60
`define SNC_OP_ARM 8'h59
`define SNC_OP_DISARM 8'h19
`define SNC_OP_WR_ENABLE 8'h06
`define SNC_OP_SLEEP 8'hB9
`define SNC_OP_SNWR 8'hC2
`define SNC_OP_SNRD 8'hC3
`define SNC_OP_IDRD 8'h9F
// Identity fields, values arbitrary
`define SNC_ID_BANK 3'h5
`define SNC_ID_MAKER 8'hA5
`define SNC_ID_PRODUCT 14'h2AAA
`define SNC_ID_DENSITY 4'h3
`define SNC_ID_REV 3'h2
// Identity field positions
`define SNC_ID_MFG_MSB 31
`define SNC_ID_PROD_MSB 20
`define SNC_ID_DENS_MSB 6
`define SNC_ID_REV_MSB 2
// Serial number
`define SNC_SN_BYTES 8
`define SNC_SN_RESET 8'h00
// Times in ns and clock period
`define SNC_CLK_NS 20
`define SNC_SEQ_NS 500
`define SNC_WAKE_NS 20000
`define SNC_SEQ_CYC ((`SNC_SEQ_NS + `SNC_CLK_NS - 1) / `SNC_CLK_NS)
`define SNC_WAKE_CYC ((`SNC_WAKE_NS + `SNC_CLK_NS - 1) / `SNC_CLK_NS)
`endif

// [snc_host.sv]
`timescale 1ns/1ns
`default_nettype none
module snc_host (
    input wire logic clk_sys,
    input wire logic so_wire,
    output logic cs_n_pin,
    output logic sck_pin,
    output logic si_pin
);
    initial begin
        cs_n_pin = 1'b1;
        sck_pin = 1'b0;
        si_pin = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////////////////
    // Mode 0 frame; clock stands low between frames, idle input keeps toggling
    task automatic xfer(input logic [7:0] op, input logic [63:0] wd, input int wb,
        input int rb, output logic [71:0] rd);
        int n;
        logic [71:0] tx;
        n = 8 + 8 * (wb + rb);
        tx = {op, wd};
        rd = '0;
        @(negedge clk_sys);
        cs_n_pin = 1'b0;
        repeat (4) @(negedge clk_sys);
        for (int i = 0; i < n; i++) begin
            si_pin = (i < 8 + 8 * wb) ? tx[71 - i] : ~si_pin;
            repeat (4) @(negedge clk_sys);
            sck_pin = 1'b1;
            repeat (4) @(negedge clk_sys);
            // Sampled late in the high phase, well clear of the launch
            if (i >= 8 + 8 * wb) begin
                rd = {rd[70:0], so_wire};
            end
            sck_pin = 1'b0;
        end
        repeat (4) @(negedge clk_sys);
        cs_n_pin = 1'b1;
        si_pin = ~si_pin;
        // Deselect needs three cycles to pass the synchroniser and clear the enable
        repeat (4) @(negedge clk_sys);
    endtask
endmodule // snc_host
`default_nettype wire

// [snc_pkg.sv]
`default_nettype none
package snc_pkg;
    typedef enum logic [2:0] {
        ST_OP, ST_SNWR, ST_SNRD, ST_IDRD, ST_IGNORE
    } snc_rx_t;
    typedef enum logic [2:0] {
        PW_IDLE, PW_BUSY, PW_SLEEP_PROC, PW_ASLEEP, PW_WAKE
    } snc_pw_t;
endpackage
`default_nettype wire

// [snc_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module snc_sync #(
    parameter bit INIT = 1'b0
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic d,
    output logic q
);
    logic s1_ff;
    logic s2_ff;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        // Reset to the pin's idle level, so no false edge follows reset
        if (!rst_n) begin
            s1_ff <= INIT;
            s2_ff <= INIT;
        end else if (ce) begin
            s1_ff <= d;
            s2_ff <= s1_ff;
        end
    end
    assign q = s2_ff;
endmodule // snc_sync
`default_nettype wire

// [snc_timer.sv]
`timescale 1ns/1ns
`default_nettype none
module snc_timer (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic start,
    input wire logic [15:0] load,
    output logic done
);
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    always_comb begin
        nxt_cnt = cnt_ff;
        if (start) begin
            nxt_cnt = load;
        end else if (cnt_ff != 16'h0000) begin
            nxt_cnt = cnt_ff - 16'h0001;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 16'h0000;
        end else if (ce) begin
            cnt_ff <= nxt_cnt;
        end
    end
    // Done is high on the last counted cycle
    assign done = (cnt_ff == 16'h0001) && !start;
endmodule // snc_timer
`default_nettype wire

// [snc_unit.sv]
`timescale 1ns/1ns
`default_nettype none
`include "snc_cfg.svh"
module snc_unit #(
    parameter bit HAS_AUTO_SAVE = 1'b1,
    parameter logic [15:0] WAKE_CYC = 16'(`SNC_WAKE_CYC)
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic cs_n_pin,
    input wire logic sck_pin,
    input wire logic si_pin,
    output logic so_out,
    output logic so_oe,
    output logic save_pin_n_out,
    output logic save_pin_n_oe,
    input wire logic sram_dirty,
    input wire logic nv_done,
    input wire logic lock_set,
    output logic save_req,
    output logic restore_req,
    output logic ready_n,
    output logic auto_save_en,
    output logic write_en,
    output logic asleep,
    output logic serial_number_lock_bit,
    output logic [63:0] serial_number
);
    ////////////////////////////////////////////////////////////////
    localparam logic [15:0] SEQ_CYC = 16'(`SNC_SEQ_CYC);
    localparam logic [31:0] ID_WORD = {`SNC_ID_BANK, `SNC_ID_MAKER,
        `SNC_ID_PRODUCT, `SNC_ID_DENSITY, `SNC_ID_REV};
    logic cs_n_s;
    logic sck_s;
    logic si_s;
    logic cs_d_ff;
    logic sck_d_ff;
    snc_sync #(.INIT(1'b1)) u_cs (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .d(cs_n_pin),
        .q(cs_n_s));
    snc_sync u_sck (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .d(sck_pin), .q(sck_s));
    snc_sync u_si (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .d(si_pin), .q(si_s));
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cs_d_ff <= 1'b1;
            sck_d_ff <= 1'b0;
        end else if (ce) begin
            cs_d_ff <= cs_n_s;
            sck_d_ff <= sck_s;
        end
    end
    wire cs_fall = cs_d_ff && !cs_n_s;
    wire cs_rise = !cs_d_ff && cs_n_s;
    wire sck_rise = !sck_d_ff && sck_s && !cs_n_s;
    wire sck_fall = sck_d_ff && !sck_s && !cs_n_s;
    ////////////////////////////////////////////////////////////////
    snc_pkg::snc_pw_t pw_ff;
    snc_pkg::snc_pw_t nxt_pw;
    snc_pkg::snc_rx_t rx_ff;
    snc_pkg::snc_rx_t nxt_rx;
    logic [7:0] sh_ff;
    logic [7:0] nxt_sh;
    logic [2:0] bit_ff;
    logic [2:0] nxt_bit;
    logic [3:0] byte_ff;
    logic [3:0] nxt_byte;
    logic [7:0] tx_ff;
    logic [7:0] nxt_tx;
    logic so_ff;
    logic nxt_so;
    logic wen_ff;
    logic nxt_wen;
    logic wen_clr_ff;
    logic nxt_wen_clr;
    logic ase_ff;
    logic nxt_ase;
    logic lock_ff;
    logic nxt_lock;
    logic [7:0] sn_mem [0:`SNC_SN_BYTES-1];
    logic sn_we;
    logic [2:0] sn_wa;
    logic [7:0] sn_wd;
    logic save_ff;
    logic nxt_save;
    logic restore_ff;
    logic nxt_restore;
    logic nv_busy_ff;
    logic nxt_nv_busy;
    logic save_pin_ff;
    logic nxt_save_pin;
    logic tm_start;
    logic [15:0] tm_load;
    logic tm_done;
    snc_timer u_tm (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .start(tm_start),
        .load(tm_load), .done(tm_done));
    wire [7:0] rx_byte = {sh_ff[6:0], si_s};
    wire byte_end = sck_rise && (bit_ff == 3'h7);
    wire active = (pw_ff == snc_pkg::PW_IDLE) || (pw_ff == snc_pkg::PW_BUSY);
    function automatic logic [7:0] id_byte(input logic [3:0] idx);
        id_byte = ID_WORD[8'(31 - 8 * idx) -: 8];
    endfunction
    ////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_rx = rx_ff;
        nxt_sh = sh_ff;
        nxt_bit = bit_ff;
        nxt_byte = byte_ff;
        nxt_tx = tx_ff;
        nxt_so = so_ff;
        nxt_wen = wen_ff;
        nxt_wen_clr = wen_clr_ff;
        nxt_ase = ase_ff;
        nxt_lock = lock_ff;
        nxt_save = 1'b0;
        nxt_restore = 1'b0;
        nxt_nv_busy = nv_busy_ff;
        nxt_save_pin = save_pin_ff;
        nxt_pw = pw_ff;
        tm_start = 1'b0;
        tm_load = SEQ_CYC;
        sn_we = 1'b0;
        sn_wa = byte_ff[2:0];
        sn_wd = rx_byte;
        if (nv_done) begin
            nxt_nv_busy = 1'b0;
            nxt_save_pin = 1'b0;
        end
        if (lock_set) begin
            nxt_lock = 1'b1;
        end
        if (active && cs_fall) begin
            nxt_rx = snc_pkg::ST_OP;
            nxt_bit = 3'h0;
            nxt_byte = 4'h0;
            nxt_so = 1'b0;
        end else if (active && !cs_n_s) begin
            if (sck_rise) begin
                nxt_sh = rx_byte;
                nxt_bit = bit_ff + 3'h1;
            end
            if (byte_end) begin
                unique case (rx_ff)
                    snc_pkg::ST_OP: begin
                        nxt_rx = snc_pkg::ST_IGNORE;
                        if (rx_byte == `SNC_OP_WR_ENABLE) begin
                            nxt_wen = 1'b1;
                        end else if (wen_ff && (rx_byte == `SNC_OP_SAVE)) begin
                            nxt_save = 1'b1;
                            nxt_nv_busy = 1'b1;
                            nxt_wen_clr = 1'b1;
                        end else if (wen_ff && (rx_byte == `SNC_OP_RESTORE)) begin
                            nxt_restore = 1'b1;
                            nxt_nv_busy = 1'b1;
                            nxt_wen_clr = 1'b1;
                        end else if (wen_ff && ((rx_byte == `SNC_OP_ARM)
                                || (rx_byte == `SNC_OP_DISARM))) begin
                            if (HAS_AUTO_SAVE) begin
                                nxt_ase = (rx_byte == `SNC_OP_ARM);
                                nxt_pw = snc_pkg::PW_BUSY;
                                tm_start = 1'b1;
                            end
                            nxt_wen_clr = 1'b1;
                        end else if (rx_byte == `SNC_OP_SLEEP) begin
                            nxt_pw = snc_pkg::PW_SLEEP_PROC;
                            tm_start = 1'b1;
                        end else if (wen_ff && (rx_byte == `SNC_OP_SNWR)) begin
                            nxt_rx = snc_pkg::ST_SNWR;
                            nxt_wen_clr = 1'b1;
                        end else if (rx_byte == `SNC_OP_SNRD) begin
                            nxt_rx = snc_pkg::ST_SNRD;
                            nxt_tx = sn_mem[0];
                        end else if (rx_byte == `SNC_OP_IDRD) begin
                            nxt_rx = snc_pkg::ST_IDRD;
                            nxt_tx = id_byte(4'h0);
                        end
                    end
                    snc_pkg::ST_SNWR: begin
                        if ((byte_ff < 4'(`SNC_SN_BYTES)) && !lock_ff) begin
                            sn_we = 1'b1;
                        end
                        if (byte_ff < 4'(`SNC_SN_BYTES)) begin
                            nxt_byte = byte_ff + 4'h1;
                        end
                    end
                    snc_pkg::ST_SNRD, snc_pkg::ST_IDRD, snc_pkg::ST_IGNORE: begin
                    end
                endcase
            end
            // Output shifts on falling clock, MSB first
            if (sck_fall && ((rx_ff == snc_pkg::ST_SNRD) || (rx_ff == snc_pkg::ST_IDRD))) begin
                nxt_so = tx_ff[7];
                nxt_tx = {tx_ff[6:0], 1'b0};
                if (bit_ff == 3'h0) begin
                    nxt_so = tx_ff[7];
                end
            end
            if (byte_end && (rx_ff == snc_pkg::ST_SNRD)) begin
                nxt_byte = (byte_ff < 4'(`SNC_SN_BYTES)) ? byte_ff + 4'h1 : byte_ff;
                nxt_tx = (byte_ff < 4'(`SNC_SN_BYTES - 1)) ? sn_mem[3'(byte_ff + 4'h1)] : 8'h00;
            end
            if (byte_end && (rx_ff == snc_pkg::ST_IDRD)) begin
                nxt_byte = (byte_ff < 4'h4) ? byte_ff + 4'h1 : byte_ff;
                nxt_tx = (byte_ff < 4'h3) ? id_byte(byte_ff + 4'h1) : 8'h00;
            end
        end
        if (active && cs_rise && wen_clr_ff) begin
            nxt_wen = 1'b0;
            nxt_wen_clr = 1'b0;
        end
        unique case (pw_ff)
            snc_pkg::PW_IDLE: begin
            end
            snc_pkg::PW_BUSY: begin
                if (tm_done) begin
                    nxt_pw = snc_pkg::PW_IDLE;
                end
            end
            snc_pkg::PW_SLEEP_PROC: begin
                if (tm_done) begin
                    if (sram_dirty) begin
                        nxt_save = 1'b1;
                        nxt_nv_busy = 1'b1;
                        nxt_save_pin = 1'b1;
                    end
                    nxt_pw = snc_pkg::PW_ASLEEP;
                end
            end
            snc_pkg::PW_ASLEEP: begin
                if (cs_fall && !nv_busy_ff) begin
                    nxt_pw = snc_pkg::PW_WAKE;
                    tm_start = 1'b1;
                    tm_load = WAKE_CYC;
                end
            end
            snc_pkg::PW_WAKE: begin
                if (tm_done) begin
                    nxt_pw = snc_pkg::PW_IDLE;
                    nxt_rx = snc_pkg::ST_IGNORE;
                end
            end
        endcase
    end
    ////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_ff <= snc_pkg::ST_IGNORE;
            pw_ff <= snc_pkg::PW_IDLE;
            sh_ff <= 8'h00;
            bit_ff <= 3'h0;
            byte_ff <= 4'h0;
            tx_ff <= 8'h00;
            so_ff <= 1'b0;
            wen_ff <= 1'b0;
            wen_clr_ff <= 1'b0;
            ase_ff <= HAS_AUTO_SAVE;
            lock_ff <= 1'b0;
            save_ff <= 1'b0;
            restore_ff <= 1'b0;
            nv_busy_ff <= 1'b0;
            save_pin_ff <= 1'b0;
        end else if (ce) begin
            rx_ff <= nxt_rx;
            pw_ff <= nxt_pw;
            sh_ff <= nxt_sh;
            bit_ff <= nxt_bit;
            byte_ff <= nxt_byte;
            tx_ff <= nxt_tx;
            so_ff <= nxt_so;
            wen_ff <= nxt_wen;
            wen_clr_ff <= nxt_wen_clr;
            ase_ff <= nxt_ase;
            lock_ff <= nxt_lock;
            save_ff <= nxt_save;
            restore_ff <= nxt_restore;
            nv_busy_ff <= nxt_nv_busy;
            save_pin_ff <= nxt_save_pin;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `SNC_SN_BYTES; i++) begin
                sn_mem[i] <= `SNC_SN_RESET;
            end
        end else if (ce && sn_we) begin
            sn_mem[sn_wa] <= sn_wd;
        end
    end
    ////////////////////////////////////////////////////////////////
    // Output off unless reading
    assign so_oe = active && !cs_n_s
        && ((rx_ff == snc_pkg::ST_SNRD) || (rx_ff == snc_pkg::ST_IDRD));
    assign so_out = so_ff;
    // Busy shown on ready; save pin pulled low only during the save started by sleep
    assign save_pin_n_out = 1'b0;
    assign save_pin_n_oe = save_pin_ff;
    assign ready_n = nv_busy_ff || (pw_ff != snc_pkg::PW_IDLE);
    assign save_req = save_ff;
    assign restore_req = restore_ff;
    assign auto_save_en = ase_ff;
    assign write_en = wen_ff;
    assign asleep = (pw_ff == snc_pkg::PW_ASLEEP);
    assign serial_number_lock_bit = lock_ff;
    assign serial_number = {sn_mem[0], sn_mem[1], sn_mem[2], sn_mem[3],
        sn_mem[4], sn_mem[5], sn_mem[6], sn_mem[7]};
    ////////////////////////////////////////////////////////////////
    property p_wen_clear;
        @(posedge clk_sys) disable iff (!rst_n)
        (ce && active && cs_rise && wen_clr_ff) |=> !wen_ff;
    endproperty
    a_wen_clear: assert property (p_wen_clear) else $error("write enable kept");
    property p_save_pulse;
        @(posedge clk_sys) disable iff (!rst_n)
        save_ff |=> !save_ff;
    endproperty
    a_save_pulse: assert property (p_save_pulse) else $error("save pulse too long");
    property p_lock_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        (lock_ff && ce) |=> $stable(serial_number);
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("locked number changed");
    // Asleep: no drive, and the link shifts nothing in
    property p_sleep_oe;
        @(posedge clk_sys) disable iff (!rst_n)
        asleep |-> !so_oe ##1 ($stable(sh_ff) && $stable(bit_ff));
    endproperty
    a_sleep_oe: assert property (p_sleep_oe) else $error("output driven asleep");
    property p_save_busy;
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(save_ff) |-> ready_n;
    endproperty
    a_save_busy: assert property (p_save_busy) else $error("save not busy");
    sequence s_arm_start;
        (pw_ff == snc_pkg::PW_IDLE) ##1 (pw_ff == snc_pkg::PW_BUSY);
    endsequence
    // Busy must last, not just appear for a cycle
    property p_arm_busy;
        @(posedge clk_sys) disable iff (!rst_n)
        s_arm_start |-> (ready_n && (pw_ff == snc_pkg::PW_BUSY))[*8];
    endproperty
    a_arm_busy: assert property (p_arm_busy) else $error("arm not busy");
    property p_wen_only_opcode;
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(wen_ff) |-> $past(byte_end) && ($past(rx_byte) == `SNC_OP_WR_ENABLE);
    endproperty
    a_wen_only_opcode: assert property (p_wen_only_opcode) else $error("stray enable");
    property p_restore_wen;
        @(posedge clk_sys) disable iff (!rst_n)
        restore_ff |-> $past(wen_ff);
    endproperty
    a_restore_wen: assert property (p_restore_wen) else $error("restore without enable");
endmodule // snc_unit
`default_nettype wire

// [snc_unit_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`include "snc_cfg.svh"
module snc_unit_tb;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic sram_dirty = 1'b0;
    logic nv_done = 1'b0;
    logic lock_set = 1'b0;
    logic save_pin_seen = 1'b0;
    logic cs_n_pin, sck_pin, si_pin, so_out, so_oe, save_pin_n_out, save_pin_n_oe;
    logic save_req, restore_req, ready_n;
    logic auto_save_en, write_en, asleep, serial_number_lock_bit;
    logic [63:0] serial_number;
    logic [71:0] rd;
    wire logic so_wire;
    int fail_count = 0;
    int tests_run = 0;
    int cyc = 0;
    int n_save = 0;
    int n_rest = 0;
    int nv_wait = 0;
    assign so_wire = so_oe ? so_out : 1'bz;
    always #10 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////////////////////////
    // Short wake count keeps the run brief
    snc_unit #(.WAKE_CYC(16'h000A)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1),
        .cs_n_pin(cs_n_pin), .sck_pin(sck_pin), .si_pin(si_pin), .so_out(so_out),
        .so_oe(so_oe), .save_pin_n_out(save_pin_n_out), .save_pin_n_oe(save_pin_n_oe),
        .sram_dirty(sram_dirty),
        .nv_done(nv_done), .lock_set(lock_set), .save_req(save_req),
        .restore_req(restore_req), .ready_n(ready_n), .auto_save_en(auto_save_en),
        .write_en(write_en), .asleep(asleep),
        .serial_number_lock_bit(serial_number_lock_bit), .serial_number(serial_number));
    snc_host i_host (.clk_sys(clk_sys), .so_wire(so_wire), .cs_n_pin(cs_n_pin),
        .sck_pin(sck_pin), .si_pin(si_pin));
    ////////////////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (save_req === 1'b1) n_save <= n_save + 1;
        if (restore_req === 1'b1) n_rest <= n_rest + 1;
        if (save_pin_n_oe === 1'b1 && save_pin_n_out === 1'b0) save_pin_seen <= 1'b1;
        if (cyc == 30000) begin
            fail_count++;
            give_verdict();
        end
    end
    // Nonvolatile array finishes each request after a delay
    always @(negedge clk_sys) begin
        nv_done <= 1'b0;
        if (nv_wait == 1) nv_done <= 1'b1;
        if (nv_wait > 0) nv_wait <= nv_wait - 1;
        else if (save_req === 1'b1 || restore_req === 1'b1) nv_wait <= 20;
    end
    ////////////////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [71:0] seen, input logic [71:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        if (fail_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic do_reset();
        @(negedge clk_sys);
        rst_n = 1'b0;
        repeat (16) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
    endtask
    task automatic idle();
        int k;
        k = 0;
        while (ready_n !== 1'b0 && k < 500) begin
            @(negedge clk_sys);
            k++;
        end
        check(72'(ready_n), 72'h0);
    endtask
    task automatic cmd(input logic [7:0] op, input logic [63:0] wd, input int wb);
        i_host.xfer(`SNC_OP_WR_ENABLE, 64'h0, 0, 0, rd);
        check(72'(write_en), 72'h1);
        i_host.xfer(op, wd, wb, 0, rd);
    endtask
    ////////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset();
        check(72'(write_en), 72'h0);
        check(72'(auto_save_en), 72'h1);
        check(72'({serial_number, serial_number_lock_bit}), 72'h0);
        i_host.xfer(`SNC_OP_SAVE, 64'h0, 0, 0, rd);
        repeat (30) @(negedge clk_sys);
        check(72'({n_save[1:0], ready_n, write_en}), 72'h0);
        cmd(`SNC_OP_SAVE, 64'h0, 0);
        check(72'({write_en, ready_n}), 72'h1);
        idle();
        check(72'(n_save), 72'h1);
        cmd(`SNC_OP_RESTORE, 64'h0, 0);
        check(72'(write_en), 72'h0);
        idle();
        check(72'(n_rest), 72'h1);
        // Disarm, arm, disarm: each reports busy and drops the enable
        for (int i = 0; i < 3; i++) begin
            cmd(i == 1 ? `SNC_OP_ARM : `SNC_OP_DISARM, 64'h0, 0);
            check(72'({auto_save_en, ready_n, write_en}), 72'(i == 1 ? 3'h6 : 3'h2));
            idle();
        end
        cmd(`SNC_OP_SNWR, 64'h0123456789ABCDEF, 8);
        check(72'({serial_number, write_en}), 72'({64'h0123456789ABCDEF, 1'b0}));
        i_host.xfer(`SNC_OP_SNRD, 64'h0, 0, 9, rd);
        check(rd, {64'h0123456789ABCDEF, 8'h00});
        @(negedge clk_sys);
        lock_set = 1'b1;
        @(negedge clk_sys);
        lock_set = 1'b0;
        cmd(`SNC_OP_SNWR, 64'hFEDCBA9876543210, 8);
        check(72'({serial_number, serial_number_lock_bit}), 72'({64'h0123456789ABCDEF, 1'b1}));
        i_host.xfer(`SNC_OP_IDRD, 64'h0, 0, 4, rd);
        check(rd, 72'({`SNC_ID_BANK, `SNC_ID_MAKER, `SNC_ID_PRODUCT, `SNC_ID_DENSITY,
            `SNC_ID_REV}));
        // Sleep with clean then dirty SRAM; the wake frame itself is not decoded
        for (int i = 0; i < 2; i++) begin
            sram_dirty = i[0];
            i_host.xfer(`SNC_OP_SLEEP, 64'h0, 0, 0, rd);
            repeat (100) @(negedge clk_sys);
            sram_dirty = 1'b0;
            check(72'({asleep, so_oe}), 72'h2);
            check(72'(n_save), 72'(1 + i));
            check(72'(save_pin_seen), 72'(i));
            i_host.xfer(`SNC_OP_WR_ENABLE, 64'h0, 0, 0, rd);
            repeat (20) @(negedge clk_sys);
            check(72'({asleep, write_en}), 72'h0);
        end
        do_reset();
        check(72'({serial_number, serial_number_lock_bit, auto_save_en}), 72'h1);
        give_verdict();
    end
endmodule // snc_unit_tb
`default_nettype wire
